/* File: sim/audio_irq_ctrl_test.sv */
// Purpose: Self-checking bench for the interrupt and soft-reset block
// Assumes: reg_master drives the register port
// Notes:   FIFO levels packed {rx_full, rx_empty, tx_full, tx_empty}
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error at %0t: got %h want %h", $time, g, e); end end
module audio_irq_ctrl_test;
  import irq_regs_pkg::*;
  logic        clk_sys = 1'h0;
  logic        reset_n = 1'h0;
  logic        rx_mode = 1'h1;
  logic        rx_sample_valid = 1'h1;
  logic [3:0]  ev = 4'h0;
  logic [3:0]  fifo = 4'h5;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, rx_sample_keep, irq, core_reset;
  int          a;
  int          error_cnt = 0;
  int          checks = 0;
  always #5 clk_sys = ~clk_sys;
  audio_irq_ctrl uut (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready(), .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp(), .s_axi_rvalid, .s_axi_rready, .rx_mode,
    .cs_changed(ev[3]), .preamble_err(ev[2]), .bmc_err(ev[1]),
    .block_start(ev[0]), .rx_sample_valid, .rx_sample_keep,
    .tx_fifo_empty(fifo[0]), .tx_fifo_full(fifo[1]),
    .rx_fifo_empty(fifo[2]), .rx_fifo_full(fifo[3]), .irq, .core_reset);
  reg_master m (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
  task complete_run;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task rchk(input logic [7:0] ad, input logic [31:0] e);
    m.rd(ad, d);
    `CHK(d, e)
  endtask : rchk
  task wchk(input logic [7:0] ad, input logic [31:0] v, input logic [1:0] e);
    m.wr(ad, v, r);
    `CHK(r, e)
  endtask : wchk
  task pulse(input logic [3:0] e);
    @(negedge clk_sys);
    ev = e;
    #1 `CHK(rx_sample_keep, ~e[1])
    @(negedge clk_sys);
    ev = 4'h0;
    repeat (2) @(negedge clk_sys);
  endtask : pulse
  always @(negedge clk_sys) if (m.hang) begin
    error_cnt++;
    $display("Error at %0t: bus wait timed out", $time);
    complete_run;
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    reset_n = 1'h1;
    // Both empties stand high at release: no empty flag may follow
    rchk(OFS_FLAGS, 32'h0);
    rchk(OFS_MASK, 32'h0);
    wchk(OFS_MASK, 32'h3F, RESP_OKAY);
    rchk(OFS_MASK, 32'h3F);
    wchk(OFS_GLOBAL_GATE, 32'h8000_0000, RESP_OKAY);
    for (int i = 2; i < 6; i++) begin
      pulse(4'h1 << (i - 2));
      if (i == 2) begin
        rchk(OFS_FLAGS, 32'h0);
        pulse(4'h1);
      end
      rchk(OFS_FLAGS, 32'h1 << i);
      `CHK(irq, 1'h1)
      wchk(OFS_FLAGS, 32'h1 << i, RESP_OKAY);
      rchk(OFS_FLAGS, 32'h0);
    end
    pulse(4'h8);
    rx_mode = 1'h0;
    repeat (2) @(negedge clk_sys);
    `CHK(irq, 1'h0)
    rx_mode = 1'h1;
    repeat (2) @(negedge clk_sys);
    `CHK(irq, 1'h1)
    wchk(OFS_GLOBAL_GATE, 32'h0, RESP_OKAY);
    `CHK(irq, 1'h0)
    wchk(OFS_FLAGS, 32'h20, RESP_OKAY);
    rx_mode = 1'h0;
    pulse(4'hF);
    rchk(OFS_FLAGS, 32'h0);
    rx_sample_valid = 1'h0;
    #1 `CHK(rx_sample_keep, 1'h0)
    @(negedge clk_sys) rx_sample_valid = 1'h1;
    fifo = 4'h0;
    for (int k = 0; k < 2; k++) begin
      rx_mode = k[0];
      a = 2 * k;
      fifo[3 - a] = 1'h1;
      @(negedge clk_sys) fifo[a] = 1'h1;
      @(negedge clk_sys) fifo[a] = 1'h0;
      fifo[a + 1] = 1'h1;
      repeat (2) @(negedge clk_sys);
      rchk(OFS_FLAGS, 32'h3);
      wchk(OFS_FLAGS, 32'h3, RESP_OKAY);
      fifo = 4'h0;
    end
    wchk(OFS_CORE_RESET, 32'h5, RESP_SLVERR);
    wchk(8'h30, 32'h1, RESP_SLVERR);
    rchk(8'h30, 32'h0);
    wchk(OFS_GLOBAL_GATE, 32'h8000_0000, RESP_OKAY);
    wchk(OFS_FLAGS, 32'h1, RESP_OKAY);
    `CHK(irq, 1'h1)
    wchk(OFS_CORE_RESET, 32'hA, RESP_OKAY);
    rchk(OFS_FLAGS, 32'h0);
    rchk(OFS_MASK, 32'h0);
    rchk(OFS_GLOBAL_GATE, 32'h0);
    `CHK(irq, 1'h0)
    rchk(OFS_CORE_RESET, 32'h0);
    complete_run;
  end
endmodule : audio_irq_ctrl_test

/* File: sim/irq_regs_properties.sv */
// Purpose: Port-level checks of the interrupt and soft-reset block
// Assumes: One clock domain, clk_sys
// Notes:   Bound to audio_irq_ctrl below
`timescale 1ns/100ps
module irq_checker
  import irq_regs_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              reset_n,
  // Register port
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  // Sample path and outputs
  input wire logic              rx_sample_valid,
  input wire logic              bmc_err,
  input wire logic              rx_sample_keep,
  input wire logic              irq,
  input wire logic              core_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire rst_wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid
              & (s_axi_awaddr == OFS_CORE_RESET);
  wire key_ok = s_axi_wdata[KEY_MSB:0] == RESET_KEY;
  wire rst_rd = s_axi_arvalid & s_axi_arready
              & (s_axi_araddr == OFS_CORE_RESET);
  chk_pulse_len: assert property (
    rst_wr && key_ok |=> core_reset[*4] ##1 !core_reset)
    else $error("core reset pulse length wrong");
  chk_resp_held: assert property (
    rst_wr && key_ok |=> (!s_axi_bvalid)[*4] ##1
      (s_axi_bvalid && s_axi_bresp == RESP_OKAY))
    else $error("soft reset response timing wrong");
  chk_bad_key: assert property (
    rst_wr && !key_ok |=> s_axi_bvalid && !core_reset
      && s_axi_bresp == RESP_SLVERR)
    else $error("bad key not refused");
  chk_reset_irq: assert property (
    $fell(core_reset) |=> !irq)
    else $error("irq survives soft reset");
  chk_start_quiet: assert property (
    !$past(reset_n) |-> !irq && !core_reset)
    else $error("outputs active after reset");
  chk_drop_bad: assert property (
    rx_sample_valid && bmc_err |-> !rx_sample_keep)
    else $error("bad sample kept");
  chk_keep_good: assert property (
    rx_sample_valid && !bmc_err |-> rx_sample_keep)
    else $error("good sample dropped");
  chk_rst_unread: assert property (
    rst_rd |=> s_axi_rvalid && s_axi_rdata == '0)
    else $error("soft reset register readable");
  chk_read_okay: assert property (
    s_axi_rvalid |-> s_axi_rresp == RESP_OKAY)
    else $error("read response not okay");
  chk_ready_pair: assert property (
    s_axi_awready == s_axi_wready)
    else $error("address and data ready split");
  cover property (rst_wr && key_ok);
  cover property (rst_wr && !key_ok);
  cover property ($rose(irq));
endmodule : irq_checker

bind audio_irq_ctrl irq_checker chk (.clk_sys, .reset_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .rx_sample_valid,
  .bmc_err, .rx_sample_keep, .irq, .core_reset);

/* File: sim/reg_master.sv */
// Purpose: Processor model on the register port
// Assumes: Drives on falling edges of clk_sys
// Notes:   hang rises when a bounded wait runs out
`timescale 1ns/100ps
module reg_master (
  // Clock
  input  wire logic        clk_sys,
  // Write side
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read side
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  logic hang = 1'h0;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // Whole words only, so the key lands in the low nibble
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    @(negedge clk_sys);
    s_axi_awaddr = a;
    s_axi_wdata = v;
    s_axi_awvalid = 1'h1;
    s_axi_wvalid = 1'h1;
    s_axi_bready = 1'h1;
    #1;
    for (n = 0; n < 50 && !s_axi_awready; n++) #10;
    @(negedge clk_sys);
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    for (; n < 50 && !s_axi_bvalid; n++) @(negedge clk_sys);
    r = s_axi_bresp;
    if (n == 50) hang = 1'h1;
    @(negedge clk_sys);
    s_axi_bready = 1'h0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    @(negedge clk_sys);
    s_axi_araddr = a;
    s_axi_arvalid = 1'h1;
    s_axi_rready = 1'h1;
    #1;
    for (n = 0; n < 50 && !s_axi_arready; n++) #10;
    @(negedge clk_sys);
    s_axi_arvalid = 1'h0;
    for (; n < 50 && !s_axi_rvalid; n++) @(negedge clk_sys);
    v = s_axi_rdata;
    if (n == 50) hang = 1'h1;
    @(negedge clk_sys);
    s_axi_rready = 1'h0;
  endtask : rd
endmodule : reg_master

/* File: verilog/audio_irq_ctrl.sv */
// Purpose: Interrupt flags, mask, global gate and keyed soft reset
// Assumes: AXI4-Lite register port on clk_sys; event inputs on clk_sys
// Notes:   Soft reset clears the interrupt registers only
// Behaviour
// [RULE1] Writing one to a flag bit inverts it; zero leaves it.
// [RULE2] All flag bits clear on reset.
// [RULE3] Bit 5 sets when captured channel status changes.
// [RULE4] Bit 4 sets on a malformed preamble in receive mode.
// [RULE5] Bit 3 sets on a biphase-mark violation in data bits.
// [RULE6] A sample with a biphase-mark violation is discarded.
// [RULE7] Bit 2 sets on start of block, from the second block.
// [RULE8] Bit 1 sets when the active FIFO goes non-empty to empty.
// [RULE9] Bit 0 sets when the active FIFO becomes full.
// [RULE10] Mask register is read/write, six bits, resets to zero.
// [RULE11] Receive-only enables have no effect in transmit mode.
// [RULE12] Interrupt passes only while global gate bit 31 is one.
// [RULE13] Interrupt is a level: gate and any flag with its mask.
// [RULE14] Key 0xA in bits 3:0 gives a four-clock core reset pulse.
// [RULE15] Write response withheld until the reset pulse ends.
// [RULE16] Any other key: no reset, response is slave error.
// [RULE17] Soft reset restores the interrupt registers to defaults.
// [RULE18] Soft reset register is write-only, reads zero.
// [RULE19] Software writes the key into the low nibble of the word.
`timescale 1ns/100ps
module audio_irq_ctrl
  import irq_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Mode and receiver events, one-cycle pulses
  input  wire logic                rx_mode,
  input  wire logic                cs_changed,
  input  wire logic                preamble_err,
  input  wire logic                bmc_err,
  input  wire logic                block_start,
  // Receiver sample path
  input  wire logic                rx_sample_valid,
  output logic                     rx_sample_keep,
  // FIFO levels
  input  wire logic                tx_fifo_empty,
  input  wire logic                tx_fifo_full,
  input  wire logic                rx_fifo_empty,
  input  wire logic                rx_fifo_full,
  // Outputs to system and core
  output logic                     irq,
  output logic                     core_reset
);

  typedef enum logic [1:0] {
    WR_IDLE  = 2'b00,
    WR_RESET = 2'b01,
    WR_RESP  = 2'b10
  } wr_state_t;

  wr_state_t                 wr_state_r;
  logic [NUM_EVENTS-1:0]     flags_r;
  logic [NUM_EVENTS-1:0]     mask_r;
  logic                      gate_r;
  logic                      seen_block_r;
  logic [1:0]                bresp_r;
  logic                      rvalid_r;
  logic [DATA_W-1:0]         rdata_r;
  logic [DATA_W-1:0]         rdata_nxt;
  logic                      wr_fire;
  logic                      key_ok;
  logic                      rst_start;
  logic                      rst_done;
  logic                      soft_clr;
  logic                      empty_sel;
  logic                      full_sel;
  logic                      empty_rise;
  logic                      full_rise;
  logic [NUM_EVENTS-1:0]     set_vec;
  logic [NUM_EVENTS-1:0]     toggle_vec;
  logic [NUM_EVENTS-1:0]     eff_mask;
  logic                      sel_gate;
  logic                      sel_flags;
  logic                      sel_mask;
  logic                      sel_reset;
  logic [1:0]                bresp_nxt;
  logic                      irq_nxt;

  // Write channel: address and data taken together in idle
  assign wr_fire       = (wr_state_r == WR_IDLE) && s_axi_awvalid
                         && s_axi_wvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_bvalid  = (wr_state_r == WR_RESP);
  assign s_axi_bresp   = bresp_r;

  // Write decode, one target at a time
  always_comb begin
    sel_gate  = 1'b0;
    sel_flags = 1'b0;
    sel_mask  = 1'b0;
    sel_reset = 1'b0;
    if (s_axi_awaddr == OFS_GLOBAL_GATE) begin
      sel_gate = 1'b1;
    end else if (s_axi_awaddr == OFS_FLAGS) begin
      sel_flags = 1'b1;
    end else if (s_axi_awaddr == OFS_MASK) begin
      sel_mask = 1'b1;
    end else if (s_axi_awaddr == OFS_CORE_RESET) begin
      sel_reset = 1'b1;
    end
  end

  assign key_ok    = (s_axi_wdata[KEY_MSB:0] == RESET_KEY); // [RULE19]
  assign rst_start = wr_fire && sel_reset && key_ok
                     && s_axi_wstrb[0]; // [RULE14]

  // Refused key and unmapped words both answer with an error
  always_comb begin
    bresp_nxt = RESP_SLVERR;
    if (sel_reset) begin
      if (key_ok && s_axi_wstrb[0]) begin
        bresp_nxt = RESP_OKAY; // [RULE15]
      end else begin
        bresp_nxt = RESP_SLVERR; // [RULE16]
      end
    end else if (sel_gate || sel_flags || sel_mask) begin
      bresp_nxt = RESP_OKAY;
    end
  end

  soft_reset_pulse u_pulse (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .start     (rst_start),
    .pulse_out (core_reset),
    .done      (rst_done)
  );

  // Clearing in the last pulse cycle keeps the registers in step with core
  assign soft_clr = rst_done; // [RULE17]

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_state_r <= WR_IDLE;
    end else begin
      case (wr_state_r)
        WR_IDLE: begin
          if (rst_start) begin
            wr_state_r <= WR_RESET; // [RULE15]
          end else if (wr_fire) begin
            wr_state_r <= WR_RESP;
          end
        end
        WR_RESET: begin
          if (rst_done) begin
            wr_state_r <= WR_RESP; // [RULE15]
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_r <= WR_IDLE;
          end
        end
        default: begin
          wr_state_r <= WR_IDLE;
        end
      endcase
    end
  end

  // Code captured at the take, held while the response stands
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bresp_r <= bresp_nxt;
    end
  end

  // Active FIFO follows the mode
  assign empty_sel = rx_mode ? rx_fifo_empty : tx_fifo_empty;
  assign full_sel  = rx_mode ? rx_fifo_full  : tx_fifo_full;

  // Empty flag only on a non-empty to empty change
  event_edge u_empty_edge (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .level_in (empty_sel),
    .rise_out (empty_rise)
  ); // [RULE8]

  event_edge u_full_edge (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .level_in (full_sel),
    .rise_out (full_rise)
  ); // [RULE9]

  // First block only arms the start-of-block flag
  always_ff @(posedge clk_sys) begin
    if (!reset_n || soft_clr) begin
      seen_block_r <= 1'b0;
    end else if (rx_mode && block_start) begin
      seen_block_r <= 1'b1; // [RULE7]
    end
  end

  always_comb begin
    set_vec                 = '0;
    set_vec[BIT_CS_CHANGE]  = rx_mode & cs_changed;     // [RULE3]
    set_vec[BIT_PRE_ERR]    = rx_mode & preamble_err;   // [RULE4]
    set_vec[BIT_BMC_ERR]    = rx_mode & bmc_err;        // [RULE5]
    set_vec[BIT_SOB]        = rx_mode & block_start
                              & seen_block_r;           // [RULE7]
    set_vec[BIT_FIFO_EMPTY] = empty_rise;               // [RULE8]
    set_vec[BIT_FIFO_FULL]  = full_rise;                // [RULE9]
  end

  // Sample dropped when a coding violation hits it
  assign rx_sample_keep = rx_sample_valid & ~bmc_err; // [RULE6]

  assign toggle_vec = (wr_fire && sel_flags && s_axi_wstrb[0])
                      ? s_axi_wdata[NUM_EVENTS-1:0] : '0;

  // A new event beats a toggle in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n || soft_clr) begin
      flags_r <= FLAGS_RESET; // [RULE2]
    end else begin
      flags_r <= (flags_r ^ toggle_vec) | set_vec; // [RULE1]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || soft_clr) begin
      mask_r <= MASK_RESET; // [RULE10]
    end else if (wr_fire && sel_mask && s_axi_wstrb[0]) begin
      mask_r <= s_axi_wdata[NUM_EVENTS-1:0]; // [RULE10]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || soft_clr) begin
      gate_r <= GATE_RESET;
    end else if (wr_fire && sel_gate && s_axi_wstrb[3]) begin
      gate_r <= s_axi_wdata[BIT_GATE];
    end
  end

  // Receive-only sources are blinded in transmit mode
  assign eff_mask = rx_mode ? mask_r
                            : (mask_r & ~RX_ONLY_EVENTS); // [RULE11]

  // Level output, lags the flags by one clock
  always_comb begin
    irq_nxt = 1'b0;
    if (gate_r) begin
      irq_nxt = |(flags_r & eff_mask); // [RULE12] [RULE13]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

  // Read channel, one request outstanding
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = RESP_OKAY;

  always_comb begin
    rdata_nxt = '0;
    if (s_axi_araddr == OFS_GLOBAL_GATE) begin
      rdata_nxt[BIT_GATE] = gate_r;
    end else if (s_axi_araddr == OFS_FLAGS) begin
      rdata_nxt[NUM_EVENTS-1:0] = flags_r;
    end else if (s_axi_araddr == OFS_MASK) begin
      rdata_nxt[NUM_EVENTS-1:0] = mask_r;
    end else begin
      rdata_nxt = '0; // [RULE18]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
    end else if (!rvalid_r && s_axi_arvalid) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rdata_nxt;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : audio_irq_ctrl

/* File: verilog/event_edge.sv */
// Purpose: Rising-edge detector turning a level into a one-cycle event
// Assumes: Input is on clk_sys
// Notes:   Used for FIFO full/empty transitions
`timescale 1ns/100ps
module event_edge (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Level in, event out
  input  wire logic level_in,
  output logic      rise_out
);

  logic level_r;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      // Loaded from the input so a level high at release is no edge
      level_r <= level_in;
    end else begin
      level_r <= level_in;
    end
  end

  assign rise_out = level_in & ~level_r;

endmodule : event_edge

/* File: verilog/irq_regs_pkg.sv */
// Purpose: Shared constants for the audio interrupt and soft-reset block
// Assumes: 32-bit register port, byte addresses, 100 MHz clk_sys
// Notes:   Offsets are byte addresses on the register port
package irq_regs_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          NUM_EVENTS      = 6;

  // Register offsets
  localparam logic [7:0]  OFS_GLOBAL_GATE = 8'h1C;
  localparam logic [7:0]  OFS_FLAGS       = 8'h20;
  localparam logic [7:0]  OFS_MASK        = 8'h28;
  localparam logic [7:0]  OFS_CORE_RESET  = 8'h40;

  // Field positions
  localparam int          BIT_GATE        = 31;
  localparam int          BIT_CS_CHANGE   = 5;
  localparam int          BIT_PRE_ERR     = 4;
  localparam int          BIT_BMC_ERR     = 3;
  localparam int          BIT_SOB         = 2;
  localparam int          BIT_FIFO_EMPTY  = 1;
  localparam int          BIT_FIFO_FULL   = 0;
  localparam int          KEY_MSB         = 3;

  // Reset values and key
  localparam logic [5:0]  FLAGS_RESET     = 6'h00;
  localparam logic [5:0]  MASK_RESET      = 6'h00;
  localparam logic        GATE_RESET      = 1'b0;
  localparam logic [3:0]  RESET_KEY       = 4'hA;

  // Events ignored in transmit mode
  localparam logic [5:0]  RX_ONLY_EVENTS  = 6'h3C;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Soft reset pulse length
  localparam int          SOFT_RST_CLOCKS = 4;
  localparam int          SOFT_RST_CNT_W  = 3;

endpackage : irq_regs_pkg

/* File: verilog/soft_reset_pulse.sv */
// Purpose: Issues the fixed-length core reset pulse
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes:   done pulses in the last cycle of the pulse
`timescale 1ns/100ps
module soft_reset_pulse
  import irq_regs_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Control
  input  wire logic start,
  output logic      pulse_out,
  output logic      done
);

  logic [SOFT_RST_CNT_W-1:0] cnt_r;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else if (start && cnt_r == '0) begin
      cnt_r <= SOFT_RST_CNT_W'(SOFT_RST_CLOCKS);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign pulse_out = (cnt_r != '0);
  assign done      = (cnt_r == SOFT_RST_CNT_W'(1));

endmodule : soft_reset_pulse
